// [hw/sadc_ctrl.v]
// APB register block and control of the 8-bit successive-approximation converter
// Overview of operation
// - Writing one to start bit while not busy begins conversion of the selected channel.
// - Start bit clears itself once conversion has begun; never reads set.
// - Channel codes 0010 to 0101 pick the four analog channels; others reserved.
// - Input disable bit zero enables analog inputs, one disables them.
// - Time field codes 010 to 110 select 78 to 1248 clock periods.
// - Ladder control zero connects only during conversion, one always.
// - Top two bits of second control read as undefined; tests mask them.
// - On completion result, end flag and done interrupt update together.
// - Reading the result register clears the end flag.
// - Busy flag sets at start, clears at finish or STOP entry.
// - Status bits 7, 6 and 3..0 are unstable; only flags meaningful.
// - Restart before reading clears end flag; old result stays until done.
// - STOP entry aborts conversion and resets both control registers.
// - Control register writes are ignored while STOP mode lasts.
// - STOP entry disconnects the ladder regardless of ladder control.
`timescale 1ns/100ps
`include "sadc_defines.vh"

module sadc_ctrl (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire stop_mode,
    input wire cmp_high,
    output reg [7:0] dac_code,
    output reg [3:0] channel_select_field,
    output reg channel_valid,
    output reg input_disable_bit,
    output reg ladder_on,
    output reg sample_hold,
    output reg done_interrupt
);

    reg [7:0] adc_control_one_r;
    reg [7:0] adc_control_two_r;
    reg [7:0] adc_result_r;
    reg end_flag_r;
    reg stop_d_r;
    reg [31:0] rdata_nxt;
    reg slverr_nxt;
    reg [2:0] steps_left_r;
    wire access;
    wire wr_ok;
    wire rd_result;
    wire start_go;
    wire stop_entry;
    wire busy_w;
    wire done_w;
    wire sar_step;
    wire [7:0] trial_w;

    // Decode of a mapped word address
    function known_addr;
        input [11:0] a;
        begin
            known_addr = (a == `SADC_ADDR_CTRL1) || (a == `SADC_ADDR_CTRL2) ||
                         (a == `SADC_ADDR_RESULT) || (a == `SADC_ADDR_STATUS);
        end
    endfunction

    // Access phase; one-wait answer is fixed so pready is a flop
    assign access = psel && penable && pready;
    assign wr_ok = access && pwrite && !stop_mode;
    assign rd_result = access && !pwrite && (paddr == `SADC_ADDR_RESULT);
    assign start_go = wr_ok && (paddr == `SADC_ADDR_CTRL1) && pwdata[`SADC_C1_START] && !busy_w;
    assign stop_entry = stop_mode && !stop_d_r;

    // Ready answers in the second access cycle, giving one wait state
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= psel && penable && !pready;
        end
    end

    // STOP edge detect; level is synchronous so no synchroniser needed
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stop_d_r <= 1'b0;
        end else begin
            stop_d_r <= stop_mode;
        end
    end

    // Control registers; STOP holds them at reset values for its whole duration
    // reinit on STOP
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            adc_control_one_r <= `SADC_C1_RESET;
            adc_control_two_r <= `SADC_C2_RESET;
        end else if (stop_mode) begin
            adc_control_one_r <= `SADC_C1_RESET;
            adc_control_two_r <= `SADC_C2_RESET;
        end else if (wr_ok && paddr == `SADC_ADDR_CTRL1) begin
            adc_control_one_r <= {1'b0, pwdata[6:0]};
        end else if (wr_ok && paddr == `SADC_ADDR_CTRL2) begin
            adc_control_two_r <= {2'b00, pwdata[5:0]};
        end
    end

    // Timer: counts conversion periods and raises done for one cycle
    sadc_timer u_timer (
        .pclk(pclk),
        .presetn(presetn),
        .start(start_go),
        .abort(stop_mode),
        .time_code(adc_control_two_r[`SADC_C2_TIME_MSB:`SADC_C2_TIME_LSB]),
        .busy_r(busy_w),
        .done_r(done_w),
        .bad_code_r()
    );

    // Place the eight decisions in the first 64 periods of the conversion: one step every eight periods
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            steps_left_r <= 3'd0;
        end else if (start_go || stop_mode) begin
            steps_left_r <= 3'd0;
        end else if (busy_w) begin
            steps_left_r <= steps_left_r + 3'd1;
        end
    end
    assign sar_step = busy_w && (steps_left_r == 3'd7);

    sadc_sar u_sar (
        .pclk(pclk),
        .presetn(presetn),
        .start(start_go),
        .abort(stop_mode),
        .step(sar_step),
        .cmp_high(cmp_high),
        .trial_r(trial_w)
    );

    // Result and end flag; completion set wins over a simultaneous read clear
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            adc_result_r <= 8'h00;
            end_flag_r <= 1'b0;
        end else if (stop_entry) begin
            // Result is indeterminate after STOP; clear it to a known value
            adc_result_r <= 8'h00;
            end_flag_r <= 1'b0;
        end else if (done_w) begin
            adc_result_r <= trial_w;
            end_flag_r <= 1'b1;
        end else if (rd_result || start_go) begin
            end_flag_r <= 1'b0;
        end
    end

    // Read mux; undefined and unstable bits read as zero
    always @* begin
        rdata_nxt = 32'h0000_0000;
        slverr_nxt = 1'b0;
        case (paddr)
            `SADC_ADDR_CTRL1: rdata_nxt[7:0] = adc_control_one_r;
            `SADC_ADDR_CTRL2: rdata_nxt[7:0] = {2'b00, adc_control_two_r[5:0]};
            `SADC_ADDR_RESULT: rdata_nxt[7:0] = adc_result_r;
            `SADC_ADDR_STATUS: begin
                rdata_nxt[`SADC_ST_END] = end_flag_r;
                rdata_nxt[`SADC_ST_BUSY] = busy_w;
            end
            default: slverr_nxt = !known_addr(paddr);
        endcase
    end

    // Registered bus answer, captured in the cycle ready rises
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (psel && penable && !pready) begin
            prdata <= pwrite ? 32'h0000_0000 : rdata_nxt;
            pslverr <= slverr_nxt;
        end else begin
            pslverr <= 1'b0;
        end
    end

    // Analog-side controls, all registered
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dac_code <= 8'h00;
            channel_select_field <= 4'h0;
            channel_valid <= 1'b0;
            input_disable_bit <= 1'b1;
            ladder_on <= 1'b0;
            sample_hold <= 1'b0;
            done_interrupt <= 1'b0;
        end else begin
            dac_code <= trial_w;
            channel_select_field <= adc_control_one_r[`SADC_C1_CH_MSB:`SADC_C1_CH_LSB];
            channel_valid <= (adc_control_one_r[`SADC_C1_CH_MSB:`SADC_C1_CH_LSB] >= `SADC_CH_FIRST) &&
                             (adc_control_one_r[`SADC_C1_CH_MSB:`SADC_C1_CH_LSB] <= `SADC_CH_LAST);
            input_disable_bit <= adc_control_one_r[`SADC_C1_INDIS];
            ladder_on <= !stop_mode && (adc_control_two_r[`SADC_C2_LADDER] || busy_w || start_go);
            sample_hold <= start_go;
            done_interrupt <= done_w && !stop_mode;
        end
    end

endmodule // sadc_ctrl

// [hw/sadc_defines.vh]
// Register offsets, field positions, reset values and timing counts of the converter block
`ifndef SADC_DEFINES_VH
`define SADC_DEFINES_VH

// Printed offsets are not all multiples of four: kept as indices, byte address is four times
`define SADC_IDX_CTRL1 8'h0E
`define SADC_IDX_CTRL2 8'h0F
`define SADC_IDX_RESULT 8'h20
`define SADC_IDX_STATUS 8'h21
`define SADC_ADDR_CTRL1 12'h038
`define SADC_ADDR_CTRL2 12'h03C
`define SADC_ADDR_RESULT 12'h080
`define SADC_ADDR_STATUS 12'h084

// First control register fields
`define SADC_C1_START 7
`define SADC_C1_FIX0 6
`define SADC_C1_FIX1 5
`define SADC_C1_INDIS 4
`define SADC_C1_CH_MSB 3
`define SADC_C1_CH_LSB 0
`define SADC_C1_RESET 8'h10

// Second control register fields
`define SADC_C2_LADDER 5
`define SADC_C2_ONE 4
`define SADC_C2_TIME_MSB 3
`define SADC_C2_TIME_LSB 1
`define SADC_C2_ZERO 0
`define SADC_C2_RESET 8'h00

// Status register fields
`define SADC_ST_END 5
`define SADC_ST_BUSY 4

// Channel codes: first channel is 0010, last 0101
`define SADC_CH_FIRST 4'h2
`define SADC_CH_LAST 4'h5

// Conversion time codes and lengths in high-frequency clock periods
`define SADC_TIME_78 3'h2
`define SADC_TIME_156 3'h3
`define SADC_TIME_312 3'h4
`define SADC_TIME_624 3'h5
`define SADC_TIME_1248 3'h6
`define SADC_FC_78 11'd78
`define SADC_FC_156 11'd156
`define SADC_FC_312 11'd312
`define SADC_FC_624 11'd624
`define SADC_FC_1248 11'd1248

`endif

// [hw/sadc_timer.v]
// Conversion timer: counts high-frequency clock periods and pulses completion once
`timescale 1ns/100ps
`include "sadc_defines.vh"

module sadc_timer (
    input wire pclk,
    input wire presetn,
    input wire start,
    input wire abort,
    input wire [2:0] time_code,
    output reg busy_r,
    output reg done_r,
    output reg bad_code_r
);

    reg [10:0] count_r;

    // Length of one conversion for a time code; reserved codes yield zero
    // time code lengths
    function [10:0] conv_len;
        input [2:0] code;
        begin
            case (code)
                `SADC_TIME_78: conv_len = `SADC_FC_78;
                `SADC_TIME_156: conv_len = `SADC_FC_156;
                `SADC_TIME_312: conv_len = `SADC_FC_312;
                `SADC_TIME_624: conv_len = `SADC_FC_624;
                `SADC_TIME_1248: conv_len = `SADC_FC_1248;
                default: conv_len = 11'd0;
            endcase
        end
    endfunction

    // Count down from start; reserved code falls back to shortest time so busy never hangs
    // count then pulse
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_r <= 11'd0;
            busy_r <= 1'b0;
            done_r <= 1'b0;
            bad_code_r <= 1'b0;
        end else if (abort) begin
            count_r <= 11'd0;
            busy_r <= 1'b0;
            done_r <= 1'b0;
        end else if (start && !busy_r) begin
            bad_code_r <= (conv_len(time_code) == 11'd0);
            // Load the full length so busy stands for exactly N periods
            count_r <= (conv_len(time_code) == 11'd0) ? `SADC_FC_78 : conv_len(time_code);
            busy_r <= 1'b1;
            done_r <= 1'b0;
        end else if (busy_r) begin
            if (count_r == 11'd1) begin
                busy_r <= 1'b0;
                done_r <= 1'b1;
            end else begin
                done_r <= 1'b0;
            end
            count_r <= count_r - 11'd1;
        end else begin
            done_r <= 1'b0;
        end
    end

endmodule // sadc_timer

// [hw/sadc_sar.v]
// Successive-approximation sequencer: one decision per step against the comparator input
`timescale 1ns/100ps

module sadc_sar (
    input wire pclk,
    input wire presetn,
    input wire start,
    input wire abort,
    input wire step,
    input wire cmp_high,
    output reg [7:0] trial_r
);

    reg [7:0] bit_r;

    // Walk from MSB to LSB; keep a bit when the input sits above the trial level
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trial_r <= 8'h00;
            bit_r <= 8'h00;
        end else if (abort) begin
            trial_r <= 8'h00;
            bit_r <= 8'h00;
        end else if (start) begin
            trial_r <= 8'h80;
            bit_r <= 8'h80;
        end else if (step && bit_r != 8'h00) begin
            trial_r <= (cmp_high ? trial_r : (trial_r & ~bit_r)) | (bit_r >> 1);
            bit_r <= bit_r >> 1;
        end
    end

endmodule // sadc_sar

// [sim/sadc_ctrl_sva.sv]
// Port checker for the converter control block, bound to its top module
`timescale 1ns/100ps
module sadc_ctrl_chk (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire stop_mode,
    input wire [3:0] channel_select_field,
    input wire input_disable_bit,
    input wire ladder_on,
    input wire sample_hold,
    input wire done_interrupt
);
    // Decode of the four mapped words; anything else must raise an error
    wire mapped = paddr == 12'h038 || paddr == 12'h03C || paddr == 12'h080 || paddr == 12'h084;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    pready_pulse_a: assert property (pready |=> !pready)
        else $error("pready held for more than one cycle");
    pready_access_a: assert property (pready |-> psel && penable)
        else $error("pready outside an access phase");
    slverr_decode_a: assert property (pready |-> pslverr == !mapped)
        else $error("pslverr does not match address decode");
    rdata_upper_a: assert property (pready && !pwrite |-> prdata[31:8] == 24'h000000)
        else $error("upper read data bits not zero");
    done_pulse_a: assert property (done_interrupt |=> !done_interrupt)
        else $error("done interrupt longer than one cycle");
    stop_ladder_a: assert property (stop_mode ##1 stop_mode |-> !ladder_on)
        else $error("ladder connected during stop");
    // Registers reset one edge into STOP, the pin copies one edge later
    stop_regs_a: assert property (stop_mode [*3] |-> input_disable_bit && channel_select_field == 4'h0)
        else $error("control fields not at reset value in stop");
    sample_pulse_a: assert property (sample_hold |=> !sample_hold)
        else $error("sample pulse longer than one cycle");

    // Main scenarios reached
    cover property (done_interrupt);
    cover property (pready && pslverr);
    cover property (stop_mode && !ladder_on);
endmodule // sadc_ctrl_chk

bind sadc_ctrl sadc_ctrl_chk chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .stop_mode(stop_mode), .channel_select_field(channel_select_field),
    .input_disable_bit(input_disable_bit), .ladder_on(ladder_on), .sample_hold(sample_hold),
    .done_interrupt(done_interrupt));

// [sim/test_sar_adc_control_regs.sv]
// Self-checking testbench of the converter control block over APB
`timescale 1ns/100ps
`include "sadc_defines.vh"
module test_sar_adc_control_regs;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic stop_mode = 1'b0;
    logic cmp_high = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata, q;
    logic [7:0] dac_code;
    logic [3:0] channel_select_field;
    logic pready, pslverr, channel_valid, input_disable_bit, ladder_on, sample_hold;
    logic done_interrupt, e;
    int fails = 0;
    int checks_done = 0;
    int k;

    always #20 pclk = ~pclk;

    sadc_ctrl dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .stop_mode(stop_mode), .cmp_high(cmp_high), .dac_code(dac_code),
        .channel_select_field(channel_select_field), .channel_valid(channel_valid),
        .input_disable_bit(input_disable_bit), .ladder_on(ladder_on),
        .sample_hold(sample_hold), .done_interrupt(done_interrupt));

    // One APB transfer; entered just after a rising edge, held until pready is sampled
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [7:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h000000, d};
        penable <= 1'b0;
        @(posedge pclk);
        penable <= 1'b1;
        // Wait for the answer; only the watchdog ends a stuck wait
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Idle edge so the next setup never re-drives psel in this time step
        @(posedge pclk);
    endtask

    task automatic cmp(input string nm, input logic [31:0] x, input logic [31:0] got);
        checks_done++;
        if (got !== x) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, x, got);
        end
    endtask

    // Masked register read; undefined bits are masked off
    task automatic rd(input logic [11:0] a, input logic [7:0] m, input logic [7:0] x,
        input string nm);
        xfer(1'b0, a, 8'h00);
        cmp(nm, {24'h000000, x}, q & {24'h000000, m});
    endtask

    // Start a conversion, optionally peek while busy, then wait for the done pulse
    task automatic run_conv(input int n, input bit peek);
        xfer(1'b1, `SADC_ADDR_CTRL1, 8'hA3);
        cmp("sample pulse", 1, sample_hold);
        if (peek) begin
            rd(`SADC_ADDR_STATUS, 8'h30, 8'h10, "status restarted");
            rd(`SADC_ADDR_RESULT, 8'hFF, 8'hFF, "old result kept");
        end
        k = 0;
        do begin
            @(posedge pclk);
            k++;
            if (k == 5) cmp("ladder while busy", 1, ladder_on);
        end while (done_interrupt !== 1'b1);
        // N busy periods from the accepting edge, then flag and interrupt one edge later
        if (!peek) cmp("conversion cycles", n + 1, k);
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Hang guard, well above the few thousand cycles the tests take
    initial begin
        repeat (20000) @(posedge pclk);
        fails++;
        tally_and_finish;
    end

    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(`SADC_ADDR_CTRL1, 8'hFF, 8'h10, "ctrl1 reset");
        rd(`SADC_ADDR_CTRL2, 8'h3F, 8'h00, "ctrl2 reset");
        rd(`SADC_ADDR_RESULT, 8'hFF, 8'h00, "result reset");
        rd(`SADC_ADDR_STATUS, 8'h30, 8'h00, "status reset");
        xfer(1'b0, 12'h000, 8'h00);
        cmp("unmapped error", 1, e);
        $display("test reset values done");
        for (int c = 0; c < 16; c++) begin
            xfer(1'b1, `SADC_ADDR_CTRL1, 8'h20 | 8'(c));
            repeat (2) @(posedge pclk);
            cmp("channel valid", c >= 2 && c <= 5, channel_valid);
            cmp("channel field", c, channel_select_field);
        end
        cmp("inputs enabled", 0, input_disable_bit);
        xfer(1'b1, `SADC_ADDR_CTRL1, 8'h30);
        repeat (2) @(posedge pclk);
        cmp("inputs disabled", 1, input_disable_bit);
        $display("test channel select done");
        for (int t = 2; t < 8; t++) begin
            cmp_high <= t[0];
            xfer(1'b1, `SADC_ADDR_CTRL1, 8'h23);
            xfer(1'b1, `SADC_ADDR_CTRL2, 8'h10 | 8'(t << 1));
            rd(`SADC_ADDR_CTRL2, 8'h3F, 8'h10 | 8'(t << 1), "ctrl2 readback");
            run_conv(t == 7 ? 78 : 78 << (t - 2), 1'b0);
            rd(`SADC_ADDR_STATUS, 8'h30, 8'h20, "status done");
            rd(`SADC_ADDR_CTRL1, 8'hFF, 8'h23, "start self clear");
            cmp("ladder after run", 0, ladder_on);
            cmp("dac code", {8{t[0]}}, dac_code);
            rd(`SADC_ADDR_RESULT, 8'hFF, {8{t[0]}}, "result");
            rd(`SADC_ADDR_STATUS, 8'h30, 8'h00, "end flag cleared");
        end
        $display("test conversion times done");
        cmp_high <= 1'b1;
        run_conv(78, 1'b0);
        cmp_high <= 1'b0;
        run_conv(78, 1'b1);
        rd(`SADC_ADDR_RESULT, 8'hFF, 8'h00, "new result");
        $display("test restart before read done");
        xfer(1'b1, `SADC_ADDR_CTRL2, 8'h34);
        repeat (2) @(posedge pclk);
        cmp("ladder always on", 1, ladder_on);
        xfer(1'b1, `SADC_ADDR_CTRL1, 8'hA3);
        repeat (5) @(posedge pclk);
        stop_mode <= 1'b1;
        repeat (3) @(posedge pclk);
        cmp("ladder in stop", 0, ladder_on);
        xfer(1'b1, `SADC_ADDR_CTRL1, 8'h2F);
        xfer(1'b1, `SADC_ADDR_CTRL2, 8'h3C);
        rd(`SADC_ADDR_CTRL1, 8'hFF, 8'h10, "ctrl1 in stop");
        rd(`SADC_ADDR_CTRL2, 8'h3F, 8'h00, "ctrl2 in stop");
        rd(`SADC_ADDR_STATUS, 8'h30, 8'h00, "busy cleared");
        stop_mode <= 1'b0;
        repeat (100) @(posedge pclk);
        rd(`SADC_ADDR_STATUS, 8'h30, 8'h00, "no restart");
        $display("test stop entry done");
        tally_and_finish;
    end
endmodule // test_sar_adc_control_regs
